// ### logic/cmd_sec_pkg.sv
`default_nettype none
package cmd_sec_pkg;
   // Frame geometry
   localparam int OCTET_W = 8;
   localparam int OCTETS = 4;
   localparam int FRAME_W = 32;
   localparam int SEQ_W = 4;
   localparam int HIST_MAX = 16;
   localparam int LEN_W = 5;
   // Bit positions inside one octet
   localparam int ID_BIT = 7;
   localparam int AUX_BIT = 6;
   localparam int CHK_LSB = 3;
   localparam int DAT_LSB = 0;
   // Clock cycles between frame starts at the sender
   localparam int FRAME_DIV = 16;
   // Values after reset
   localparam logic [SEQ_W-1:0] SEQ_RESET = 4'h0;
   localparam logic [HIST_MAX-1:0] HIST_RESET = 16'h0000;
   // Discriminator offset scale, full scale and one-third floor
   localparam logic [7:0] OFFSET_FULL = 8'hFF;
   localparam logic [7:0] OFFSET_FLOOR = 8'h55;
   // Discriminator report codes
   localparam logic [1:0] DISC_TRIP = 2'h1;
   localparam logic [1:0] DISC_GUARD = 2'h2;
   localparam logic [1:0] DISC_NOISE = 2'h3;
   // Counter widths for tone timers and level words
   localparam int TIME_W = 16;
   localparam int LEVEL_W = 10;

   // Shortened Hamming check bits, distance three over three data bits
   function automatic logic [2:0] hamming_check(input logic [2:0] d);
      hamming_check = {d[1] ^ d[2], d[0] ^ d[2], d[0] ^ d[1]};
   endfunction : hamming_check

   // Assemble one octet: id, aux, check, data
   function automatic logic [7:0] make_octet(input logic first, input logic aux,
                                             input logic [2:0] d);
      make_octet = {first, aux, hamming_check(d), d};
   endfunction : make_octet
endpackage : cmd_sec_pkg
`default_nettype wire

// ### logic/cmd_link_if.sv
`default_nettype none
// Octet stream between the sending terminal and the receiving terminal
interface cmd_link_if (
   input wire logic clk_in,
   input wire logic rstn_in
);
   logic [7:0] octet; // One octet of a frame
   logic valid; // Octet offered
   logic ready; // Octet accepted when high with valid
   modport sender (input clk_in, input rstn_in, input ready, output octet, output valid);
   modport receiver (input clk_in, input rstn_in, input octet, input valid, output ready);
endinterface : cmd_link_if
`default_nettype wire

// ### logic/cmd_frame_sender.sv
`default_nettype none
// Sending end: builds one four-octet frame on each frame tick that finds it idle
module cmd_frame_sender #(
   parameter int FRAME_CYCLES = cmd_sec_pkg::FRAME_DIV
) (
   cmd_link_if.sender link,
   input wire logic trip_in,
   input wire logic guard_in,
   input wire logic supervisory_in,
   output logic frame_sent_out
);
   typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;
   tx_state_t state_q, state_d; // Sender state
   logic [15:0] div_q, div_d; // Frame rate divider
   logic [1:0] idx_q, idx_d; // Octet index in flight
   logic [cmd_sec_pkg::SEQ_W-1:0] seq_q, seq_d; // Sequence count
   logic [7:0] octet_q, octet_d; // Octet on the link
   logic trip_q, trip_d, guard_q, guard_d, sup_q, sup_d; // Latched frame content
   logic sent_q, sent_d; // Frame done pulse
   logic tick; // Frame rate enable

   // Octet content for a given index
   function automatic logic [7:0] octet_at(input logic [1:0] i, input logic t,
                                           input logic g, input logic s,
                                           input logic [3:0] q);
      case (i)
         2'h0: octet_at = cmd_sec_pkg::make_octet(1'b1, s, {t, g, q[3]}); // [RQ2] [RQ7]
         2'h1: octet_at = cmd_sec_pkg::make_octet(1'b0, 1'b1, q[2:0]);
         2'h2: octet_at = cmd_sec_pkg::make_octet(1'b0, 1'b1, {~t, ~g, 1'b0}); // [RQ11]
         default: octet_at = cmd_sec_pkg::make_octet(1'b0, 1'b1, 3'h0);
      endcase
   endfunction : octet_at

   assign tick = (div_q == 16'(FRAME_CYCLES - 1));
   assign link.valid = (state_q == TX_SEND);
   assign link.octet = octet_q;
   assign frame_sent_out = sent_q;

   // Next state of divider, framing and sequence
   always_comb begin
      state_d = state_q;
      div_d = tick ? 16'h0000 : div_q + 16'h0001;
      idx_d = idx_q;
      seq_d = seq_q;
      octet_d = octet_q;
      trip_d = trip_q;
      guard_d = guard_q;
      sup_d = sup_q;
      sent_d = 1'b0;
      case (state_q)
         TX_IDLE: begin
            // Latch inputs and present the first octet
            if (tick) begin
               trip_d = trip_in;
               guard_d = guard_in;
               sup_d = supervisory_in;
               idx_d = 2'h0;
               octet_d = octet_at(2'h0, trip_in, guard_in, supervisory_in, seq_q); // [RQ1]
               state_d = TX_SEND;
            end
         end
         TX_SEND: begin
            // Advance on each accepted octet
            if (link.ready) begin
               if (idx_q == 2'h3) begin
                  seq_d = seq_q + 4'h1; // [RQ7]
                  sent_d = 1'b1;
                  state_d = TX_IDLE;
               end else begin
                  idx_d = idx_q + 2'h1;
                  octet_d = octet_at(idx_q + 2'h1, trip_q, guard_q, sup_q, seq_q); // [RQ1] [RQ3]
               end
            end
         end
         default: state_d = TX_IDLE;
      endcase
   end

   // Registers
   always_ff @(posedge link.clk_in or negedge link.rstn_in) begin
      if (!link.rstn_in) begin
         state_q <= TX_IDLE;
         div_q <= 16'h0000;
         idx_q <= 2'h0;
         seq_q <= cmd_sec_pkg::SEQ_RESET;
         octet_q <= 8'h00;
         trip_q <= 1'b0;
         guard_q <= 1'b0;
         sup_q <= 1'b0;
         sent_q <= 1'b0;
      end else begin
         state_q <= state_d;
         div_q <= div_d;
         idx_q <= idx_d;
         seq_q <= seq_d;
         octet_q <= octet_d;
         trip_q <= trip_d;
         guard_q <= guard_d;
         sup_q <= sup_d;
         sent_q <= sent_d;
      end
   end
endmodule : cmd_frame_sender
`default_nettype wire

// ### logic/cmd_frame_receiver.sv
// Operation
// [RQ1] Command is one frame of four octets
// [RQ2] Octet: data, check, aux, identification bits
// [RQ3] Hamming check catches single and double errors
// [RQ4] Separate trip and guard history, up to 16
// [RQ5] Shift one on valid one, else zero
// [RQ6] Validated when ones reach the threshold
// [RQ7] Sender adds a four-bit sequence count
// [RQ8] Mismatched sequence count invalidates the frame
// [RQ9] After mismatch, resync and need clean frame
// [RQ10] Valid only if 31 bits and sequence good
// [RQ11] Complementary paths; drive off when processor stops
// [RQ12] Combine both discriminators into command state
// [RQ13] Noise for inhibit time raises inhibit alarm
// [RQ14] Offset from threshold over window, floor one third
// [RQ15] Hysteresis: no forced guard, hold last state
// [RQ16] Correlation timer flags disagreeing dual channels
// [RQ17] Loss from noise, level limits and overload
// [RQ18] No loss while tone within level limits
// [RQ19] Dual system needs both receivers lost
// [RQ20] Loss event logged and counter incremented
// [RQ21] Command means trip asserted, guard not
// [RQ22] Identification bit marks the first octet
`default_nettype none
module cmd_frame_receiver (
   cmd_link_if.receiver link,
   input wire logic hold_in,
   input wire logic run_ok_in,
   input wire logic [cmd_sec_pkg::LEN_W-1:0] window_len_in,
   input wire logic [cmd_sec_pkg::LEN_W-1:0] threshold_in,
   input wire logic voice_band_tone_mode_in,
   input wire logic [3:0] disc_poly_in,
   input wire logic [3:0] disc_phase_in,
   input wire logic [2*cmd_sec_pkg::LEVEL_W-1:0] level_in,
   input wire logic [cmd_sec_pkg::LEVEL_W-1:0] level_min_in,
   input wire logic [cmd_sec_pkg::LEVEL_W-1:0] level_max_in,
   input wire logic [1:0] overload_in,
   input wire logic [cmd_sec_pkg::TIME_W-1:0] qual_time_in,
   input wire logic [cmd_sec_pkg::TIME_W-1:0] inhibit_time_in,
   input wire logic [cmd_sec_pkg::TIME_W-1:0] corr_time_in,
   input wire logic hysteresis_in,
   input wire logic force_guard_in,
   input wire logic dual_channel_in,
   output logic trip_out,
   output logic guard_n_out,
   output logic trip_valid_out,
   output logic guard_valid_out,
   output logic frame_ok_out,
   output logic frame_bad_out,
   output logic seq_slip_out,
   output logic [1:0] inhibit_alarm_out,
   output logic corr_alarm_out,
   output logic tone_loss_out,
   output logic loss_event_out,
   output logic [15:0] loss_count_out,
   output logic [7:0] disc_offset_out
);
   localparam int TW = cmd_sec_pkg::TIME_W;
   localparam int LW = cmd_sec_pkg::LEVEL_W;

   // Two-entry skid buffer
   logic [7:0] buf_q [2]; // Buffer storage
   logic [7:0] buf_d [2];
   logic wr_q, wr_d, rd_q, rd_d; // Write and read pointers
   logic [1:0] cnt_q, cnt_d; // Fill level
   logic push, pop; // Buffer strobes
   logic [7:0] oct; // Octet leaving the buffer

   assign link.ready = (cnt_q != 2'h2);
   assign push = link.valid && link.ready;
   assign pop = (cnt_q != 2'h0) && !hold_in;
   assign oct = buf_q[rd_q];

   // Buffer next state
   always_comb begin
      buf_d = buf_q;
      wr_d = wr_q;
      rd_d = rd_q;
      cnt_d = cnt_q;
      if (push) begin
         buf_d[wr_q] = link.octet;
         wr_d = ~wr_q;
      end
      if (pop) begin
         rd_d = ~rd_q;
      end
      cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge link.clk_in or negedge link.rstn_in) begin
      if (!link.rstn_in) begin
         buf_q[0] <= 8'h00;
         buf_q[1] <= 8'h00;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         buf_q <= buf_d;
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // Frame assembly, checking, sequence and history
   logic [7:0] fr_q [3]; // First three octets held
   logic [7:0] fr_d [3];
   logic [1:0] idx_q, idx_d; // Next octet slot
   logic act_q, act_d; // Frame in progress
   logic [3:0] exp_q, exp_d; // Predicted sequence count
   logic rsy_q, rsy_d; // Resync pending
   logic [15:0] th_q, th_d, gh_q, gh_d; // Trip and guard history
   logic ok_q, ok_d, bad_q, bad_d, slip_q, slip_d; // Frame pulses
   logic done, code_ok, seq_match, valid; // Frame decode terms
   logic [3:0] seq_rx; // Received count
   logic [15:0] mask; // Window mask
   logic [4:0] tcnt, gcnt; // Ones in window
   logic tval, gval; // Validated paths

   // Check bits and data agree in one octet
   function automatic logic ham_ok(input logic [7:0] o);
      ham_ok = (o[5:3] == cmd_sec_pkg::hamming_check(o[2:0]));
   endfunction : ham_ok

   // Ones in a masked history
   function automatic logic [4:0] ones(input logic [15:0] v);
      logic [4:0] c;
      c = 5'h00;
      for (int i = 0; i < cmd_sec_pkg::HIST_MAX; i++) begin
         c = c + {4'h0, v[i]};
      end
      ones = c;
   endfunction : ones

   assign done = pop && act_q && !oct[cmd_sec_pkg::ID_BIT] && (idx_q == 2'h3);
   assign code_ok = ham_ok(fr_q[0]) && ham_ok(fr_q[1]) && ham_ok(fr_q[2]) && ham_ok(oct) // [RQ3]
      && fr_q[1][cmd_sec_pkg::AUX_BIT] && fr_q[2][cmd_sec_pkg::AUX_BIT] // [RQ10]
      && oct[cmd_sec_pkg::AUX_BIT] && (fr_q[2][2:1] == ~fr_q[0][2:1]); // [RQ11]
   assign seq_rx = {fr_q[0][0], fr_q[1][2:0]};
   assign seq_match = (seq_rx == exp_q); // [RQ8]
   assign valid = code_ok && seq_match && !rsy_q; // [RQ9] [RQ10]
   assign mask = (window_len_in >= 5'd16) ? 16'hFFFF : 16'((17'h1 << window_len_in) - 17'h1);
   assign tcnt = ones(th_q & mask); // [RQ4]
   assign gcnt = ones(gh_q & mask);
   assign tval = (tcnt >= threshold_in); // [RQ6]
   assign gval = (gcnt >= threshold_in); // [RQ6]

   always_comb begin
      fr_d = fr_q;
      idx_d = idx_q;
      act_d = act_q;
      exp_d = exp_q;
      rsy_d = rsy_q;
      th_d = th_q;
      gh_d = gh_q;
      ok_d = 1'b0;
      bad_d = 1'b0;
      slip_d = 1'b0;
      if (pop) begin
         if (oct[cmd_sec_pkg::ID_BIT]) begin
            // First octet restarts assembly
            fr_d[0] = oct; // [RQ22]
            idx_d = 2'h1;
            act_d = 1'b1;
         end else if (act_q && idx_q != 2'h3) begin
            // Middle octet
            fr_d[idx_q] = oct; // [RQ1]
            idx_d = idx_q + 2'h1;
         end else begin
            // Last octet or stray octet ends assembly
            act_d = 1'b0;
            idx_d = 2'h0;
         end
      end
      if (done) begin
         ok_d = valid;
         bad_d = !valid;
         if (code_ok) begin
            exp_d = seq_rx + 4'h1; // [RQ9]
            rsy_d = !seq_match; // [RQ9]
            slip_d = !seq_match;
         end else begin
            exp_d = exp_q + 4'h1; // [RQ8]
         end
         th_d = {th_q[14:0], valid && fr_q[0][2]}; // [RQ5]
         gh_d = {gh_q[14:0], valid && fr_q[0][1]}; // [RQ5]
      end
   end

   always_ff @(posedge link.clk_in or negedge link.rstn_in) begin
      if (!link.rstn_in) begin
         fr_q[0] <= 8'h00;
         fr_q[1] <= 8'h00;
         fr_q[2] <= 8'h00;
         idx_q <= 2'h0;
         act_q <= 1'b0;
         exp_q <= cmd_sec_pkg::SEQ_RESET;
         rsy_q <= 1'b1;
         th_q <= cmd_sec_pkg::HIST_RESET;
         gh_q <= cmd_sec_pkg::HIST_RESET;
         ok_q <= 1'b0;
         bad_q <= 1'b0;
         slip_q <= 1'b0;
      end else begin
         fr_q <= fr_d;
         idx_q <= idx_d;
         act_q <= act_d;
         exp_q <= exp_d;
         rsy_q <= rsy_d;
         th_q <= th_d;
         gh_q <= gh_d;
         ok_q <= ok_d;
         bad_q <= bad_d;
         slip_q <= slip_d;
      end
   end

   // Tone receivers, one per channel
   logic [1:0] st, inh, loss; // Command state, inhibit, loss per receiver
   generate
      for (genvar r = 0; r < 2; r++) begin : g_rx
         logic [TW-1:0] ic_q, ic_d, qc_q, qc_d; // Inhibit and qualify timers
         logic st_q, st_d; // One for trip state
         logic noise, want_t, want_g, lvl_ok, tone_ok; // Receiver terms
         logic [1:0] pa, pb;
         logic [LW-1:0] lvl;
         assign pa = disc_poly_in[2*r+:2];
         assign pb = disc_phase_in[2*r+:2];
         assign lvl = level_in[LW*r+:LW];
         assign noise = (pa == cmd_sec_pkg::DISC_NOISE) || (pb == cmd_sec_pkg::DISC_NOISE);
         assign want_t = (pa == cmd_sec_pkg::DISC_TRIP) && (pb == cmd_sec_pkg::DISC_TRIP); // [RQ12]
         assign want_g = (pa == cmd_sec_pkg::DISC_GUARD) && (pb == cmd_sec_pkg::DISC_GUARD);
         assign lvl_ok = (lvl >= level_min_in) && (lvl <= level_max_in) && !overload_in[r];
         assign tone_ok = (want_t || want_g) && lvl_ok; // [RQ18]
         assign loss[r] = !tone_ok && (noise || !lvl_ok); // [RQ17]
         assign inh[r] = noise && (ic_q >= inhibit_time_in); // [RQ13]
         assign st[r] = st_q;

         // Timers and state next values
         always_comb begin
            ic_d = noise ? ((ic_q == {TW{1'b1}}) ? ic_q : ic_q + 1'b1) : '0; // [RQ13]
            qc_d = '0;
            st_d = st_q;
            if ((want_t && !st_q) || (want_g && st_q)) begin
               // Qualify a change of state
               if (qc_q >= qual_time_in) begin
                  st_d = want_t; // [RQ15]
               end else begin
                  qc_d = qc_q + 1'b1;
               end
            end
            if (inh[r] && force_guard_in && !hysteresis_in) begin
               st_d = 1'b0; // [RQ13] [RQ15]
               qc_d = '0;
            end
         end

         always_ff @(posedge link.clk_in or negedge link.rstn_in) begin
            if (!link.rstn_in) begin
               ic_q <= '0;
               qc_q <= '0;
               st_q <= 1'b0;
            end else begin
               ic_q <= ic_d;
               qc_q <= qc_d;
               st_q <= st_d;
            end
         end
      end
   endgenerate

   logic tone_loss_receiver_one, tone_loss_receiver_two; // Per-receiver loss
   assign tone_loss_receiver_one = loss[0];
   assign tone_loss_receiver_two = loss[1];

   // Correlation, loss output, command drive and offset
   logic [TW-1:0] cc_q, cc_d; // Correlation timer
   logic lo_q, lo_d, ev_q, ev_d; // Loss output and event pulse
   logic [15:0] lc_q, lc_d; // Loss event counter
   logic tr_q, tr_d, gn_q, gn_d; // Output drives
   logic [7:0] off_q, off_d; // Discriminator offset
   logic cmd; // Command present
   logic [12:0] ratio; // Threshold scaled by window

   assign ratio = (window_len_in == 5'h00) ? 13'h0000
      : 13'((18'(threshold_in) * 18'(cmd_sec_pkg::OFFSET_FULL)) / 18'(window_len_in));
   assign cmd = voice_band_tone_mode_in ? (dual_channel_in ? &st : st[0])
      : (tval && !gval); // [RQ21]

   always_comb begin
      cc_d = (dual_channel_in && (st[0] != st[1])) // [RQ16]
         ? ((cc_q == {TW{1'b1}}) ? cc_q : cc_q + 1'b1) : '0;
      lo_d = dual_channel_in ? (tone_loss_receiver_one && tone_loss_receiver_two) // [RQ19]
         : tone_loss_receiver_one;
      lo_d = lo_d && voice_band_tone_mode_in;
      ev_d = lo_d && !lo_q; // [RQ20]
      lc_d = ev_d ? lc_q + 16'h0001 : lc_q; // [RQ20]
      tr_d = run_ok_in && cmd; // [RQ11] [RQ21]
      gn_d = !(run_ok_in && !cmd); // [RQ11]
      if (ratio >= 13'(cmd_sec_pkg::OFFSET_FULL)) begin
         off_d = cmd_sec_pkg::OFFSET_FULL;
      end else if (ratio[7:0] < cmd_sec_pkg::OFFSET_FLOOR) begin
         off_d = cmd_sec_pkg::OFFSET_FLOOR; // [RQ14]
      end else begin
         off_d = ratio[7:0]; // [RQ14]
      end
   end

   always_ff @(posedge link.clk_in or negedge link.rstn_in) begin
      if (!link.rstn_in) begin
         cc_q <= '0;
         lo_q <= 1'b0;
         ev_q <= 1'b0;
         lc_q <= 16'h0000;
         tr_q <= 1'b0;
         gn_q <= 1'b1;
         off_q <= cmd_sec_pkg::OFFSET_FLOOR;
      end else begin
         cc_q <= cc_d;
         lo_q <= lo_d;
         ev_q <= ev_d;
         lc_q <= lc_d;
         tr_q <= tr_d;
         gn_q <= gn_d;
         off_q <= off_d;
      end
   end

   assign trip_out = tr_q;
   assign guard_n_out = gn_q;
   assign trip_valid_out = tval;
   assign guard_valid_out = gval;
   assign frame_ok_out = ok_q;
   assign frame_bad_out = bad_q;
   assign seq_slip_out = slip_q;
   assign inhibit_alarm_out = inh;
   assign corr_alarm_out = dual_channel_in && (cc_q >= corr_time_in); // [RQ16]
   assign tone_loss_out = lo_q;
   assign loss_event_out = ev_q;
   assign loss_count_out = lc_q;
   assign disc_offset_out = off_q;
endmodule : cmd_frame_receiver
`default_nettype wire

// ### tb/cmd_link_sva.sv
`default_nettype none
// Watches the octet stream between the two terminals
module cmd_link_sva (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [7:0] octet,
   input wire logic valid,
   input wire logic ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic take; // Octet accepted this edge
   logic [1:0] idx_q; // Octet position in the frame
   logic [1:0] idx_d;
   logic [2:0] head_q; // Data bits of the first octet
   logic [2:0] head_d;
   logic [3:0] seq_q; // Last sequence count seen
   logic [3:0] seq_d;
   logic seen_q; // A count has been seen since reset
   logic seen_d;
   assign take = valid && ready;
   // Next tracking state
   always_comb begin
      idx_d = idx_q;
      head_d = head_q;
      seq_d = seq_q;
      seen_d = seen_q;
      if (take) begin
         idx_d = idx_q + 2'h1;
         if (idx_q == 2'h0) begin
            head_d = octet[2:0];
         end
         if (idx_q == 2'h1) begin
            seq_d = {head_q[0], octet[2:0]};
            seen_d = 1'b1;
         end
      end
   end
   // Register tracking state
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         idx_q <= 2'h0;
         head_q <= 3'h0;
         seq_q <= 4'h0;
         seen_q <= 1'b0;
      end else begin
         idx_q <= idx_d;
         head_q <= head_d;
         seq_q <= seq_d;
         seen_q <= seen_d;
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   AST_HOLD:
   assert property (valid && !ready |=> valid && $stable(octet))
      else $error("offered octet changed before acceptance");
   AST_BURST:
   assert property (take && idx_q != 2'h3 |=> valid)
      else $error("frame octets not back to back");
   AST_ID_FIRST:
   assert property (valid && idx_q == 2'h0 |-> octet[7])
      else $error("first octet lacks id bit");
   AST_ID_REST:
   assert property (valid && idx_q != 2'h0 |-> !octet[7] && octet[6])
      else $error("later octet id or aux bit wrong");
   AST_CHECK:
   assert property (valid |-> octet[5:3] ==
      {octet[1] ^ octet[2], octet[0] ^ octet[2], octet[0] ^ octet[1]})
      else $error("check bits wrong");
   AST_COMPL:
   assert property (valid && idx_q == 2'h2 |-> octet[2:0] == {~head_q[2:1], 1'b0})
      else $error("complement octet wrong");
   AST_TAIL:
   assert property (valid && idx_q == 2'h3 |-> octet[2:0] == 3'h0)
      else $error("last octet data not zero");
   AST_SEQ:
   assert property (valid && idx_q == 2'h1 && seen_q |->
      {head_q[0], octet[2:0]} == seq_q + 4'h1)
      else $error("sequence count did not advance");
   COV_FRAME: cover property (take && idx_q == 2'h3);
   COV_STALL: cover property (valid && !ready);
   COV_START: cover property (take && octet[7]);
endmodule : cmd_link_sva
`default_nettype wire

// ### tb/tb_top.sv
`default_nettype none
// Sender and receiver back to back, plus a hand-driven second link
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic trip_in = 1'b0, guard_in = 1'b0, sup_in = 1'b0, hold_in = 1'b0, run_ok_in = 1'b1;
   logic [4:0] window_len_in = 5'h04, threshold_in = 5'h04;
   logic [3:0] disc_poly_in = 4'h0, disc_phase_in = 4'h0;
   logic tone = 1'b0, hyst = 1'b0, fgd = 1'b0, dual = 1'b0; // Tone mode settings
   logic [1:0] ovl = 2'h0; // Receiver overload
   logic [9:0] lmin = 10'h000, lmax = 10'h3FF; // Level limits
   logic [19:0] lvl = 20'h00000; // Received levels
   logic [15:0] qt = 16'h0004, it = 16'h0004, ct = 16'h0008; // Tone timers
   logic [1:0] hold_mode = 2'h0; // Stall mode: off, random, forced
   logic trip_out, guard_n_out, trip_valid_out, guard_valid_out, sent, ok2, bad2, slip2;
   logic [7:0] disc_offset_out;
   logic got_ok = 1'b0, got_slip = 1'b0; // Pulses seen on second link
   logic [1:0] exp_q[$]; // Expected {ok, slip} per frame
   int seed, miscompares = 0, checked = 0, cycles = 0, r;
   event frame_done;
   always #4 clk_in = ~clk_in;
   cmd_link_if lk (.clk_in(clk_in), .rstn_in(rstn_in));
   cmd_link_if lk2 (.clk_in(clk_in), .rstn_in(rstn_in));
   cmd_frame_sender #(.FRAME_CYCLES(16)) u_cmd_frame_sender (.link(lk), .trip_in(trip_in),
      .guard_in(guard_in), .supervisory_in(sup_in), .frame_sent_out(sent));
   cmd_frame_receiver u_cmd_frame_receiver (.link(lk), .hold_in(hold_in), .run_ok_in(run_ok_in),
      .window_len_in(window_len_in), .threshold_in(threshold_in), .voice_band_tone_mode_in(tone),
      .disc_poly_in(disc_poly_in), .disc_phase_in(disc_phase_in), .level_in(lvl),
      .level_min_in(lmin), .level_max_in(lmax), .overload_in(ovl),
      .qual_time_in(qt), .inhibit_time_in(it), .corr_time_in(ct),
      .hysteresis_in(hyst), .force_guard_in(fgd), .dual_channel_in(dual),
      .trip_out(trip_out), .guard_n_out(guard_n_out), .trip_valid_out(trip_valid_out),
      .guard_valid_out(guard_valid_out), .frame_ok_out(), .frame_bad_out(), .seq_slip_out(),
      .inhibit_alarm_out(), .corr_alarm_out(), .tone_loss_out(), .loss_event_out(),
      .loss_count_out(), .disc_offset_out(disc_offset_out));
   cmd_frame_receiver u_cmd_frame_receiver_2 (.link(lk2), .hold_in(hold_in),
      .run_ok_in(run_ok_in), .window_len_in(window_len_in), .threshold_in(threshold_in),
      .voice_band_tone_mode_in(tone), .disc_poly_in(disc_poly_in), .disc_phase_in(disc_phase_in),
      .level_in(lvl), .level_min_in(lmin), .level_max_in(lmax), .overload_in(ovl),
      .qual_time_in(qt), .inhibit_time_in(it), .corr_time_in(ct),
      .hysteresis_in(hyst), .force_guard_in(fgd), .dual_channel_in(dual),
      .trip_out(), .guard_n_out(), .trip_valid_out(), .guard_valid_out(), .frame_ok_out(ok2),
      .frame_bad_out(bad2), .seq_slip_out(slip2), .inhibit_alarm_out(), .corr_alarm_out(),
      .tone_loss_out(), .loss_event_out(), .loss_count_out(), .disc_offset_out());
   cmd_link_sva u_cmd_link_sva (.clk_in(clk_in), .rstn_in(rstn_in), .octet(lk.octet),
      .valid(lk.valid), .ready(lk.ready));
   // Compare one value and count it
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Report and end the run
   task automatic finish_test();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test
   // Octet with our own check bits
   function automatic logic [7:0] oct(input logic id, input logic aux, input logic [2:0] d);
      oct = {id, aux, d[1] ^ d[2], d[0] ^ d[2], d[0] ^ d[1], d};
   endfunction : oct
   // Hand-built frame on the second link, err flips bits of octets 0..3
   task automatic frame2(input logic [3:0] s, input logic [31:0] err, input logic aux0,
                         input logic [1:0] e);
      logic [31:0] f;
      f = {oct(1'b1, aux0, {2'b10, s[3]}), oct(1'b0, 1'b1, s[2:0]), oct(1'b0, 1'b1, 3'h2),
           oct(1'b0, 1'b1, 3'h0)} ^ err;
      exp_q.push_back(e);
      for (int i = 3; i >= 0; i--) begin
         lk2.valid = 1'b1;
         lk2.octet = f[i*8 +: 8];
         while (lk2.ready !== 1'b1) begin
            @(posedge clk_in);
            #1;
         end
         @(posedge clk_in);
         #1;
      end
      lk2.valid = 1'b0;
      repeat (4) @(posedge clk_in);
      #1;
      -> frame_done;
   endtask : frame2
   // Catch result pulses of the second receiver
   always @(negedge clk_in) begin
      if (ok2 === 1'b1) got_ok = 1'b1;
      if (slip2 === 1'b1) got_slip = 1'b1;
   end
   // Take the oldest note and compare
   always @(frame_done) begin
      r = exp_q.pop_front();
      chk("frame_ok", {7'h00, r[1]}, {7'h00, got_ok});
      chk("seq_slip", {7'h00, r[0]}, {7'h00, got_slip});
      got_ok = 1'b0;
      got_slip = 1'b0;
   end
   // Stall and discriminator stimulus, plus hang limit
   always @(posedge clk_in) begin
      #1;
      r = $random(seed);
      disc_poly_in = r[7:4];
      disc_phase_in = r[11:8];
      hold_in = (hold_mode == 2'h2) || (hold_mode == 2'h1 && r[0]);
      cycles++;
      if (cycles > 20000) begin
         miscompares++;
         finish_test();
      end
   end
   // Main sequence
   initial begin
      seed = 17;
      lk2.valid = 1'b0;
      lk2.octet = 8'h00;
      repeat (2) @(posedge clk_in);
      #1 rstn_in = 1'b1;
      frame2(4'h0, 32'h0, 1'b1, 2'b00);
      frame2(4'h1, 32'h0, 1'b1, 2'b10);
      frame2(4'h2, 32'h0000_0001, 1'b1, 2'b00);
      frame2(4'h3, 32'h0, 1'b1, 2'b10);
      frame2(4'h9, 32'h0, 1'b1, 2'b01);
      frame2(4'hA, 32'h0, 1'b1, 2'b00);
      frame2(4'hB, 32'h0, 1'b0, 2'b10);
      frame2(4'hC, 32'h0003_0000, 1'b1, 2'b00);
      frame2(4'hD, 32'h0, 1'b1, 2'b10);
      frame2(4'hE, 32'h0000_4000, 1'b1, 2'b00);
      frame2(4'hF, 32'h0, 1'b1, 2'b10);
      trip_in = 1'b1;
      hold_mode = 2'h1;
      repeat (300) @(posedge clk_in);
      #1;
      chk("trip_valid", 8'h01, {7'h00, trip_valid_out});
      chk("guard_valid", 8'h00, {7'h00, guard_valid_out});
      chk("trip_out", 8'h01, {7'h00, trip_out});
      chk("guard_n_out", 8'h01, {7'h00, guard_n_out});
      chk("offset_full", 8'hFF, disc_offset_out);
      run_ok_in = 1'b0;
      repeat (3) @(posedge clk_in);
      #1;
      chk("trip_stopped", 8'h00, {7'h00, trip_out});
      chk("guard_stopped", 8'h01, {7'h00, guard_n_out});
      run_ok_in = 1'b1;
      hold_mode = 2'h2;
      repeat (40) @(posedge clk_in);
      #1;
      chk("ready_full", 8'h00, {7'h00, lk.ready});
      chk("valid_stands", 8'h01, {7'h00, lk.valid});
      hold_mode = 2'h0;
      trip_in = 1'b0;
      guard_in = 1'b1;
      repeat (300) @(posedge clk_in);
      #1;
      chk("trip_valid", 8'h00, {7'h00, trip_valid_out});
      chk("guard_valid", 8'h01, {7'h00, guard_valid_out});
      chk("trip_out", 8'h00, {7'h00, trip_out});
      chk("guard_n_out", 8'h00, {7'h00, guard_n_out});
      threshold_in = 5'h01;
      window_len_in = 5'h10;
      repeat (3) @(posedge clk_in);
      #1;
      chk("offset_floor", 8'h55, disc_offset_out);
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
